/* hw/pcfg_pkg.sv */
// Constants and helpers for the indirect pin mode configuration block
// Operation
// - Write with latch bit 3 clear updates selected pin's stored mode.
// - Direction bit 4: zero acts on output config, one on input config.
// - Output mode bits 7:5: 000 normal, 011 high drive; others illegal.
// - Input mode bits 6:5: 00 none, 01 pull-down, 10 pull-up, 11 off.
// - Write with latch bit set saves pin select and direction for reads.
// - Latch write ignores mode field; no pin configuration changes.
// - Read returns bits 7:5 as mode of saved pin, saved direction.
// - Pin select 000 through 111 addresses pins 0 through 7.
// - Mode update touches only the addressed pin; other seven stay.
package pcfg_pkg;
  // ==========================================================
  // Register map (index times four gives the byte address)
  localparam int PCFG_ADDR_W = 12;
  localparam logic [9:0] PCFG_CFG_IDX = 10'h097;
  localparam logic [9:0] PCFG_STAT_IDX = 10'h098;
  localparam logic [7:0] PCFG_CFG_RST = 8'h00;
  // ==========================================================
  // Field positions of the configuration byte
  localparam int PCFG_MODE_HI = 7;
  localparam int PCFG_MODE_LO = 5;
  localparam int PCFG_IN_HI = 6;
  localparam int PCFG_DIR_BIT = 4;
  localparam int PCFG_LATCH_BIT = 3;
  localparam int PCFG_PIN_HI = 2;
  localparam int PCFG_PIN_LO = 0;
  // Status register fields
  localparam int PCFG_STAT_ILL_BIT = 0;
  localparam int PCFG_STAT_DIR_BIT = 1;
  localparam int PCFG_STAT_PIN_LO = 2;
  // ==========================================================
  // Mode encodings
  localparam logic [2:0] PCFG_OUT_NORMAL = 3'h0;
  localparam logic [2:0] PCFG_OUT_HIGH = 3'h3;
  localparam logic [1:0] PCFG_IN_NOPULL = 2'h0;
  localparam logic [1:0] PCFG_IN_PDOWN = 2'h1;
  localparam logic [1:0] PCFG_IN_PUP = 2'h2;
  localparam logic [1:0] PCFG_IN_OFF = 2'h3;
  // Bus responses
  localparam logic [1:0] PCFG_RESP_OKAY = 2'h0;
  localparam logic [1:0] PCFG_RESP_SLVERR = 2'h2;

  // Word index of a byte address
  function automatic logic [9:0] pcfg_word_idx(input logic [PCFG_ADDR_W-1:0] addr);
    return addr[PCFG_ADDR_W-1:2];
  endfunction : pcfg_word_idx
endpackage : pcfg_pkg

/* hw/pcfg_axil_slave.sv */
// AXI4-Lite slave front end handing single-word accesses to the register file
`timescale 1ns/1ps
module pcfg_axil_slave (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Write address and data channels
  input wire logic [pcfg_pkg::PCFG_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels
  input wire logic [pcfg_pkg::PCFG_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register file side
  output logic wr_pulse,
  output logic [pcfg_pkg::PCFG_ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_hit,
  output logic [pcfg_pkg::PCFG_ADDR_W-1:0] rd_addr,
  input wire logic rd_hit,
  input wire logic [31:0] rd_word
);
  import pcfg_pkg::*;

  logic aw_full, next_aw_full, w_full, next_w_full;
  logic [PCFG_ADDR_W-1:0] next_wr_addr;
  logic [31:0] next_wr_data, next_rdata;
  logic [3:0] next_wr_strb;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;

  // ==========================================================
  // Handshakes: nothing is taken while the enable is low
  assign s_axi_awready = ce && !aw_full;
  assign s_axi_wready = ce && !w_full;
  assign s_axi_arready = ce && !s_axi_rvalid;
  assign wr_pulse = ce && aw_full && w_full && !s_axi_bvalid;
  assign rd_addr = s_axi_araddr;

  // Next channel state
  always_comb begin
    next_aw_full = aw_full;
    next_w_full = w_full;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full = 1'b1;
      next_wr_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full = 1'b1;
      next_wr_data = s_axi_wdata;
      next_wr_strb = s_axi_wstrb;
    end
    if (wr_pulse) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_hit ? PCFG_RESP_OKAY : PCFG_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata = rd_hit ? rd_word : 32'h0;
      next_rresp = rd_hit ? PCFG_RESP_OKAY : PCFG_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // Channel registers, frozen while the enable is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      wr_addr <= '0;
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PCFG_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= PCFG_RESP_OKAY;
    end else if (ce) begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      wr_strb <= next_wr_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end
endmodule : pcfg_axil_slave

/* hw/pcfg_top.sv */
// Indirect per-pin mode configuration register for an eight-pin port
`timescale 1ns/1ps
module pcfg_top #(
  parameter int NPINS = 8
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write channels
  input wire logic [pcfg_pkg::PCFG_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [pcfg_pkg::PCFG_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pad control
  output logic [NPINS-1:0] pad_drive_high,
  output logic [NPINS-1:0] pad_in_enable,
  output logic [NPINS-1:0] pad_pull_up,
  output logic [NPINS-1:0] pad_pull_down
);
  import pcfg_pkg::*;

  logic wr_pulse, wr_hit, rd_hit, wr_cfg, wr_stat;
  logic [PCFG_ADDR_W-1:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_word;
  logic [3:0] wr_strb;
  logic [7:0] wbyte;
  logic [2:0] out_mode [NPINS];
  logic [2:0] next_out_mode [NPINS];
  logic [1:0] in_mode [NPINS];
  logic [1:0] next_in_mode [NPINS];
  logic [2:0] pin_select, next_pin_select;
  logic read_select_latch, next_read_select_latch;
  logic illegal_seen, next_illegal_seen;
  logic [NPINS-1:0] next_drive_high, next_in_enable, next_pull_up, next_pull_down;
  logic [7:0] cfg_read;
  logic [3*NPINS-1:0] out_flat;
  logic [2*NPINS-1:0] in_flat;

  // ==========================================================
  // Bus front end
  pcfg_axil_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_pulse(wr_pulse),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_hit(wr_hit),
    .rd_addr(rd_addr),
    .rd_hit(rd_hit),
    .rd_word(rd_word)
  );

  // ==========================================================
  // Address decode and read data
  always_comb begin
    wbyte = wr_data[7:0];
    wr_hit = 1'b0;
    rd_hit = 1'b0;
    if (pcfg_word_idx(wr_addr) == PCFG_CFG_IDX) begin
      wr_hit = 1'b1;
    end else if (pcfg_word_idx(wr_addr) == PCFG_STAT_IDX) begin
      wr_hit = 1'b1;
    end
    // Only byte lane 0 carries the configuration byte
    wr_cfg = wr_pulse && wr_strb[0] && pcfg_word_idx(wr_addr) == PCFG_CFG_IDX;
    wr_stat = wr_pulse && wr_strb[0] && pcfg_word_idx(wr_addr) == PCFG_STAT_IDX;
    // Saved pin and direction pick the reported mode
    cfg_read = PCFG_CFG_RST;
    if (read_select_latch) begin
      cfg_read[PCFG_IN_HI:PCFG_MODE_LO] = in_mode[pin_select];
    end else begin
      cfg_read[PCFG_MODE_HI:PCFG_MODE_LO] = out_mode[pin_select];
    end
    rd_word = 32'h0;
    if (pcfg_word_idx(rd_addr) == PCFG_CFG_IDX) begin
      rd_hit = 1'b1;
      rd_word[7:0] = cfg_read;
    end else if (pcfg_word_idx(rd_addr) == PCFG_STAT_IDX) begin
      rd_hit = 1'b1;
      rd_word[PCFG_STAT_ILL_BIT] = illegal_seen;
      rd_word[PCFG_STAT_DIR_BIT] = read_select_latch;
      rd_word[PCFG_STAT_PIN_LO +: 3] = pin_select;
    end
  end

  // ==========================================================
  // Next pin configuration, read selection and status
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      next_out_mode[i] = out_mode[i];
      next_in_mode[i] = in_mode[i];
    end
    next_pin_select = pin_select;
    next_read_select_latch = read_select_latch;
    next_illegal_seen = illegal_seen;
    // Write-one clears the sticky flag; a new set below overrides it
    if (wr_stat && wbyte[PCFG_STAT_ILL_BIT]) begin
      next_illegal_seen = 1'b0;
    end
    if (wr_cfg) begin
      if (wbyte[PCFG_LATCH_BIT]) begin
        next_pin_select = wbyte[PCFG_PIN_HI:PCFG_PIN_LO];
        next_read_select_latch = wbyte[PCFG_DIR_BIT];
      end else if (wbyte[PCFG_DIR_BIT]) begin
        // Binary pin index, only that pin changes
        next_in_mode[wbyte[PCFG_PIN_HI:PCFG_PIN_LO]] = wbyte[PCFG_IN_HI:PCFG_MODE_LO];
      end else begin
        next_out_mode[wbyte[PCFG_PIN_HI:PCFG_PIN_LO]] = wbyte[PCFG_MODE_HI:PCFG_MODE_LO];
        if (wbyte[PCFG_MODE_HI:PCFG_MODE_LO] != PCFG_OUT_NORMAL &&
            wbyte[PCFG_MODE_HI:PCFG_MODE_LO] != PCFG_OUT_HIGH) begin
          next_illegal_seen = 1'b1;
        end
      end
    end
    // Pad controls follow the stored modes
    for (int i = 0; i < NPINS; i++) begin
      next_drive_high[i] = out_mode[i] == PCFG_OUT_HIGH;
      next_in_enable[i] = in_mode[i] != PCFG_IN_OFF;
      next_pull_up[i] = in_mode[i] == PCFG_IN_PUP;
      next_pull_down[i] = in_mode[i] == PCFG_IN_PDOWN;
    end
  end

  // Configuration and pad registers, all cleared by reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NPINS; i++) begin
        out_mode[i] <= PCFG_OUT_NORMAL;
        in_mode[i] <= PCFG_IN_NOPULL;
      end
      pin_select <= 3'h0;
      read_select_latch <= 1'b0;
      illegal_seen <= 1'b0;
      pad_drive_high <= '0;
      pad_in_enable <= '0;
      pad_pull_up <= '0;
      pad_pull_down <= '0;
    end else if (ce) begin
      for (int i = 0; i < NPINS; i++) begin
        out_mode[i] <= next_out_mode[i];
        in_mode[i] <= next_in_mode[i];
      end
      pin_select <= next_pin_select;
      read_select_latch <= next_read_select_latch;
      illegal_seen <= next_illegal_seen;
      pad_drive_high <= next_drive_high;
      pad_in_enable <= next_in_enable;
      pad_pull_up <= next_pull_up;
      pad_pull_down <= next_pull_down;
    end
  end

  // ==========================================================
  // Checks
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      out_flat[3*i +: 3] = out_mode[i];
      in_flat[2*i +: 2] = in_mode[i];
    end
  end

  AST_OUT_UPDATE: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_cfg && !wbyte[PCFG_LATCH_BIT] && !wbyte[PCFG_DIR_BIT] |=>
      out_mode[$past(wbyte[2:0])] == $past(wbyte[7:5]))
    else $error("Output mode not updated by write");
  AST_IN_UPDATE: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_cfg && !wbyte[PCFG_LATCH_BIT] && wbyte[PCFG_DIR_BIT] |=>
      in_mode[$past(wbyte[2:0])] == $past(wbyte[6:5]) && $stable(out_flat))
    else $error("Input mode write wrong");
  AST_LATCH_SAVE: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_cfg && wbyte[PCFG_LATCH_BIT] |=>
      pin_select == $past(wbyte[2:0]) && read_select_latch == $past(wbyte[4]))
    else $error("Read selection not saved");
  AST_LATCH_KEEP: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_cfg && wbyte[PCFG_LATCH_BIT] |=> $stable(out_flat) && $stable(in_flat))
    else $error("Latch write changed a pin mode");
  AST_OTHER_PINS: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_cfg && !wbyte[PCFG_LATCH_BIT] && !wbyte[PCFG_DIR_BIT] |=>
      ((out_flat ^ $past(out_flat)) & ~(24'h7 << (3 * $past(wbyte[2:0])))) == 24'h0)
    else $error("Unaddressed pin changed");
  AST_READ_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && !read_select_latch &&
      pcfg_word_idx(s_axi_araddr) == PCFG_CFG_IDX |=>
      s_axi_rvalid && s_axi_rdata[7:5] == $past(out_mode[pin_select]))
    else $error("Output mode read back wrong");
  AST_READ_IN: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && read_select_latch &&
      pcfg_word_idx(s_axi_araddr) == PCFG_CFG_IDX |=>
      s_axi_rdata[7:5] == {1'b0, $past(in_mode[pin_select])})
    else $error("Input mode read back wrong");
  AST_RESET_CLEAR: assert property (@(posedge aclk)
    $rose(aresetn) |-> out_flat == 24'h0 && in_flat == 16'h0 && pin_select == 3'h0 &&
      !read_select_latch)
    else $error("State not cleared by reset");
  AST_DRIVE_PAD: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && out_mode[0] == PCFG_OUT_HIGH |=> pad_drive_high[0])
    else $error("High drive not applied to pad");
  AST_PULL_PAD: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && in_mode[0] == PCFG_IN_OFF |=> !pad_in_enable[0] && !pad_pull_up[0])
    else $error("Disabled input still enabled");
endmodule : pcfg_top

/* verif/pcfg_axil_master.sv */
// Processor-side AXI4-Lite master model issuing single-word register accesses
`timescale 1ns/1ps
module pcfg_axil_master (
  // Clock
  input wire logic aclk,
  // Write channels
  output logic [11:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // Read channels
  output logic [11:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // ==========================================================
  // Idle bus at time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // One write; payloads held until their own handshake edge, settled values seen at negedge
  task automatic write_word(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                            output logic [1:0] r);
    logic ha, hw, hb, done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      ha = awvalid & awready;
      hw = wvalid & wready;
      hb = bready & bvalid;
      r = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) begin
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : write_word

  // One read; rready held high until rvalid is sampled
  task automatic read_word(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hr, done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      ha = arvalid & arready;
      hr = rready & rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
      if (hr) begin
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : read_word
endmodule : pcfg_axil_master

/* verif/pcfg_top_tb_top.sv */
// Self-checking testbench of the pin mode configuration block against a reference model
`timescale 1ns/1ps
module pcfg_top_tb_top;
  import pcfg_pkg::*;
  localparam logic [11:0] CFG_A = {PCFG_CFG_IDX, 2'b00};
  localparam logic [11:0] STAT_A = {PCFG_STAT_IDX, 2'b00};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [7:0] drv_hi, in_en, p_up, p_dn;
  int err_count = 0;
  int checks = 0;
  // Reference model state
  int om[8], im[8], sp, sd, ill;

  // ==========================================================
  // Clock and design
  initial forever #2 aclk = ~aclk;

  pcfg_top #(.NPINS(8)) uut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pad_drive_high(drv_hi), .pad_in_enable(in_en), .pad_pull_up(p_up), .pad_pull_down(p_dn));

  pcfg_axil_master host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // ==========================================================
  // Comparison, verdict and helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("Checks %0d, errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  // Write one config byte and apply it to the model
  task automatic cfg_write(input logic [7:0] b);
    host.write_word(CFG_A, {24'h0, b}, 4'hf, rs);
    check(32'(rs), 32'(PCFG_RESP_OKAY));
    if (b[3]) begin
      sp = b[2:0];
      sd = b[4];
    end else if (b[4]) im[b[2:0]] = b[6:5];
    else begin
      om[b[2:0]] = b[7:5];
      if (b[7:5] != 0 && b[7:5] != 3) ill = 1;
    end
  endtask : cfg_write

  // Read back the config byte and every pad line
  task automatic cfg_verify();
    logic [7:0] eh, ee, eu, ed;
    host.read_word(CFG_A, rd, rs);
    check(32'(rs), 32'(PCFG_RESP_OKAY));
    check(rd, sd ? 32'(im[sp] << 5) : 32'(om[sp] << 5));
    for (int i = 0; i < 8; i++) begin
      eh[i] = (om[i] == 3);
      ee[i] = (im[i] != 3);
      eu[i] = (im[i] == 2);
      ed[i] = (im[i] == 1);
    end
    check({drv_hi, in_en, p_up, p_dn}, {eh, ee, eu, ed});
  endtask : cfg_verify

  // ==========================================================
  // Watchdog
  initial begin
    repeat (40000) @(posedge aclk);
    err_count++;
    close_out();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] b;
    foreach (om[i]) begin
      om[i] = 0;
      im[i] = 0;
    end
    sp = 0;
    sd = 0;
    ill = 0;
    void'($urandom(32'h769642b2));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    check({drv_hi, in_en, p_up, p_dn}, 32'h0);
    cfg_verify();
    // Every pin and direction read back after reset
    for (int p = 0; p < 16; p++) begin
      cfg_write(8'(p[2:0] | (p[3] << 4) | 8'h08));
      cfg_verify();
    end
    // Every input code and the high-drive output code on every pin
    for (int p = 0; p < 8; p++) begin
      for (int m = 0; m < 4; m++) begin
        cfg_write(8'((m << 5) | 8'h10 | p));
        cfg_write(8'(8'h18 | p));
        cfg_verify();
      end
      cfg_write(8'(8'h60 | p));
      cfg_write(8'(8'h08 | p));
      cfg_verify();
    end
    // Random mix of latch and update writes, mode bits random on latch writes
    repeat (120) begin
      b = 8'($urandom);
      if (!b[3] && !b[4]) b[7:5] = b[7] ? 3'h3 : 3'h0;
      cfg_write(b);
      cfg_verify();
    end
    // Illegal output code raises the sticky flag, write one clears it
    cfg_write(8'ha5);
    cfg_verify();
    host.read_word(STAT_A, rd, rs);
    check(rd, 32'(ill | (sd << 1) | (sp << 2)));
    host.write_word(STAT_A, 32'h1, 4'hf, rs);
    check(32'(rs), 32'(PCFG_RESP_OKAY));
    ill = 0;
    host.read_word(STAT_A, rd, rs);
    check(rd, 32'(ill | (sd << 1) | (sp << 2)));
    // Byte lane zero disabled leaves the register untouched
    host.write_word(CFG_A, 32'h0000_0074, 4'he, rs);
    check(32'(rs), 32'(PCFG_RESP_OKAY));
    cfg_verify();
    // Unmapped address refused on both paths
    host.write_word(12'h100, 32'h0000_0070, 4'hf, rs);
    check(32'(rs), 32'(PCFG_RESP_SLVERR));
    host.read_word(12'h100, rd, rs);
    check(rd, 32'h0);
    check(32'(rs), 32'(PCFG_RESP_SLVERR));
    cfg_verify();
    // Enable low stalls the bus; the write lands once the enable returns
    @(posedge aclk);
    ce <= 1'b0;
    fork
      cfg_write(8'h70);
      begin
        repeat (3) @(negedge aclk);
        check(32'({awready, wready, arready, bvalid}), 32'h0);
        @(posedge aclk);
        ce <= 1'b1;
      end
    join
    cfg_verify();
    // Second reset clears every pin mode and the read selection
    @(posedge aclk);
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    foreach (om[i]) begin
      om[i] = 0;
      im[i] = 0;
    end
    sp = 0;
    sd = 0;
    ill = 0;
    cfg_verify();
    for (int p = 0; p < 8; p++) begin
      cfg_write(8'(8'h08 | p));
      cfg_verify();
    end
    close_out();
  end
endmodule : pcfg_top_tb_top
